// ===== ifx_i2c_master_model.sv
module ifx_i2c_master_model
(
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 80;
  int   stretch_ns = 0;
  logic timed_out  = 1'b0;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Release SCL, bounded stretch wait
  task automatic rise();
    scl_pull = 1'b0;
    // Let the wired SCL net settle before looking at it
    #1;
    for (int i = 0; i < 4000 && scl !== 1'b1; i++) begin
      #8;
      stretch_ns += 8;
    end
    if (scl !== 1'b1) timed_out = 1'b1;
  endtask
  task automatic bit_io(input logic b, output logic s);
    #20;
    sda_pull = ~b;
    #(HALF - 21);
    rise();
    #(HALF / 2);
    s = sda;
    #(HALF / 2);
    scl_pull = 1'b1;
  endtask
  task automatic start();
    sda_pull = 1'b1;
    #HALF;
    scl_pull = 1'b1;
  endtask
  task automatic stop();
    #20;
    sda_pull = 1'b1;
    #(HALF - 20);
    rise();
    #HALF;
    sda_pull = 1'b0;
    #HALF;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
endmodule

// ===== ifx_i2c_txctl.sv
// Operation
// R1: TX FIFO byte count readable, bits 11:8
// R2: Empty FIFO, last clear: stretch SCL low
// R3: Empty FIFO, last set: release SCL, end
// R4: STOP or repeated START clears last bit
// R5: Enabling preload mode clears ready bit
// R6: Ready clear: NACK matching slave address
// R7: Software sets ready after preloading FIFO
// R8: Preload off forces ready bit high
// R9: Data read pops oldest RX byte
// R10: Data write appends byte to TX FIFO
// R11: Empty RX read returns FF, no change
// R12: Write to full TX FIFO discarded
// R13: Match without preload flushes, locks FIFO
// R14: TX count tracks pushes, pops, flushes
module ifx_i2c_txctl
  import ifx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  logic [1:0]  ph_reg, ph_next;
  ifx_req_s    req_reg, req_next;
  logic [31:0] hrdata_reg, hrdata_next, rd_val;
  logic        preld_reg, preld_next, last_reg, last_next;
  logic        rdy_reg, rdy_next, lock_reg, lock_next;
  logic [6:0]  saddr_reg, saddr_next;
  logic        wr_en, rd_en, wr_data, rd_data, sw_last, lock_set;
  logic [7:0]  tx_mem [IFX_DEPTH];
  logic [7:0]  rx_mem [IFX_DEPTH];
  logic [2:0]  tx_wr_reg, tx_wr_next, tx_rd_reg, tx_rd_next;
  logic [2:0]  rx_wr_reg, rx_wr_next, rx_rd_reg, rx_rd_next;
  logic [3:0]  tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic        tx_push, tx_pop, tx_flush, rxf_push, rxf_pop;
  logic [7:0]  rb_d0_reg, rb_d0_next, rb_d1_reg, rb_d1_next;
  logic [1:0]  rb_cnt_reg, rb_cnt_next;
  logic        rb_push, rb_rdy, rb_vld;
  logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic        rise, fall, start, stop, addr_hit, match;
  ifx_state_e  st_reg, st_next;
  logic [3:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic        rw_reg, rw_next, sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;

  assign hreadyout = (ph_reg != IFX_PH_WAIT);
  assign hrdata    = hrdata_reg;
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_oe_reg;
  assign sda_oe    = sda_oe_reg;

  assign wr_en   = (ph_reg == IFX_PH_WAIT) && req_reg.wr;
  assign rd_en   = (ph_reg == IFX_PH_WAIT) && !req_reg.wr;
  assign wr_data = wr_en && (req_reg.ofs == IFX_OFS_DATA);
  assign rd_data = rd_en && (req_reg.ofs == IFX_OFS_DATA);
  assign sw_last = wr_en && (req_reg.ofs == IFX_OFS_CTRL1) && hwdata[IFX_B_LAST];

  // Bus phase and register file
  always_comb begin
    ph_next     = IFX_PH_IDLE;
    req_next    = req_reg;
    hrdata_next = hrdata_reg;
    preld_next  = preld_reg;
    last_next   = last_reg;
    rdy_next    = rdy_reg;
    lock_next   = lock_reg;
    saddr_next  = saddr_reg;
    rd_val      = 32'h0;
    if (hsel && htrans[1] && hready) begin
      ph_next  = IFX_PH_WAIT;
      req_next = '{ofs: haddr[7:0], wr: hwrite};
    end else if (ph_reg == IFX_PH_WAIT) begin
      ph_next = IFX_PH_DONE;
    end
    case (req_reg.ofs)
      IFX_OFS_CTRL0: rd_val[IFX_B_PRELD] = preld_reg;
      IFX_OFS_CTRL1: begin
        // R1: count field read
        rd_val[IFX_CNT_LSB+:4] = tx_cnt_reg;
        rd_val[IFX_B_LAST]     = last_reg;
        rd_val[IFX_B_RDY]      = rdy_reg;
      end
      // R9: oldest byte out
      // R11: empty reads FF
      IFX_OFS_DATA:  rd_val[7:0] = (rx_cnt_reg != 4'h0) ? rx_mem[rx_rd_reg] : IFX_EMPTY_RD;
      IFX_OFS_SADDR: rd_val[6:0] = saddr_reg;
      IFX_OFS_STAT: begin
        rd_val[IFX_CNT_LSB+:4] = rx_cnt_reg;
        rd_val[IFX_B_LOCK]     = lock_reg;
      end
      default: rd_val = 32'h0;
    endcase
    if (rd_en) begin
      hrdata_next = rd_val;
    end
    if (wr_en && req_reg.ofs == IFX_OFS_CTRL0) begin
      preld_next = hwdata[IFX_B_PRELD];
      // R5: preload enable clears ready
      if (hwdata[IFX_B_PRELD] && !preld_reg) begin
        rdy_next = 1'b0;
      end
    end
    if (wr_en && req_reg.ofs == IFX_OFS_CTRL1 && hwdata[IFX_B_RDY]) begin
      rdy_next = 1'b1;
    end
    // R8: ready forced without preload
    if (!preld_next) begin
      rdy_next = 1'b1;
    end
    // R4: bus conditions clear last
    if (start || stop || lock_set) begin
      last_next = 1'b0;
    end
    if (sw_last) begin
      last_next = 1'b1;
    end
    if (wr_en && req_reg.ofs == IFX_OFS_SADDR) begin
      saddr_next = hwdata[6:0];
    end
    if (wr_en && req_reg.ofs == IFX_OFS_STAT && hwdata[IFX_B_LOCK]) begin
      lock_next = 1'b0;
    end
    if (lock_set) begin
      lock_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg     <= IFX_PH_IDLE;
      req_reg    <= '0;
      hrdata_reg <= 32'h0;
      preld_reg  <= 1'b0;
      last_reg   <= 1'b0;
      rdy_reg    <= IFX_RST_RDY;
      lock_reg   <= 1'b0;
      saddr_reg  <= IFX_RST_SADDR;
    end else begin
      ph_reg     <= ph_next;
      req_reg    <= req_next;
      hrdata_reg <= hrdata_next;
      preld_reg  <= preld_next;
      last_reg   <= last_next;
      rdy_reg    <= rdy_next;
      lock_reg   <= lock_next;
      saddr_reg  <= saddr_next;
    end
  end

  // FIFOs and receive staging buffer
  assign rb_rdy   = (rb_cnt_reg != 2'h2);
  assign rb_vld   = (rb_cnt_reg != 2'h0);
  assign rxf_push = rb_vld && (rx_cnt_reg != IFX_FULL);
  assign rxf_pop  = rd_data && (rx_cnt_reg != 4'h0);
  assign lock_set = match && !preld_reg;
  // R13: flush and lock on match
  assign tx_flush = lock_set || (wr_en && req_reg.ofs == IFX_OFS_CTRL0 && hwdata[IFX_B_FLUSH]);
  // R10: append written byte
  // R12: full or locked drops write
  assign tx_push  = wr_data && (tx_cnt_reg != IFX_FULL) && !lock_reg;

  always_comb begin
    tx_wr_next  = tx_push ? tx_wr_reg + 3'h1 : tx_wr_reg;
    tx_rd_next  = tx_pop ? tx_rd_reg + 3'h1 : tx_rd_reg;
    // R14: count follows traffic
    tx_cnt_next = tx_cnt_reg + {3'h0, tx_push} - {3'h0, tx_pop};
    if (tx_flush) begin
      tx_rd_next  = tx_wr_reg;
      tx_wr_next  = tx_wr_reg;
      tx_cnt_next = 4'h0;
    end
    rx_wr_next  = rxf_push ? rx_wr_reg + 3'h1 : rx_wr_reg;
    rx_rd_next  = rxf_pop ? rx_rd_reg + 3'h1 : rx_rd_reg;
    rx_cnt_next = rx_cnt_reg + {3'h0, rxf_push} - {3'h0, rxf_pop};
    rb_d0_next  = rb_d0_reg;
    rb_d1_next  = rb_d1_reg;
    rb_cnt_next = rb_cnt_reg + {1'b0, rb_push} - {1'b0, rxf_push};
    if (rxf_push) begin
      rb_d0_next = rb_d1_reg;
    end
    if (rb_push) begin
      if (rb_cnt_next == 2'h1) begin
        rb_d0_next = sh_reg;
      end else begin
        rb_d1_next = sh_reg;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wr_reg  <= 3'h0;
      tx_rd_reg  <= 3'h0;
      tx_cnt_reg <= 4'h0;
      rx_wr_reg  <= 3'h0;
      rx_rd_reg  <= 3'h0;
      rx_cnt_reg <= 4'h0;
      rb_d0_reg  <= 8'h0;
      rb_d1_reg  <= 8'h0;
      rb_cnt_reg <= 2'h0;
    end else begin
      tx_wr_reg  <= tx_wr_next;
      tx_rd_reg  <= tx_rd_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_wr_reg  <= rx_wr_next;
      rx_rd_reg  <= rx_rd_next;
      rx_cnt_reg <= rx_cnt_next;
      rb_d0_reg  <= rb_d0_next;
      rb_d1_reg  <= rb_d1_next;
      rb_cnt_reg <= rb_cnt_next;
    end
  end

  always_ff @(posedge hclk) begin
    if (tx_push) begin
      tx_mem[tx_wr_reg] <= hwdata[7:0];
    end
    if (rxf_push) begin
      rx_mem[rx_wr_reg] <= rb_d0_reg;
    end
  end

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    end
  end

  assign rise     = scl_s2 && !scl_d;
  assign fall     = !scl_s2 && scl_d;
  assign start    = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop     = scl_s2 && scl_d && !sda_d && sda_s2;
  assign addr_hit = (sh_reg[7:1] == saddr_reg) || (sh_reg[7:1] == IFX_GCALL && !sh_reg[0]);

  // Slave engine
  always_comb begin
    st_next  = st_reg;
    bit_next = bit_reg;
    sh_next  = sh_reg;
    rw_next  = rw_reg;
    match    = 1'b0;
    tx_pop   = 1'b0;
    rb_push  = 1'b0;
    if (start) begin
      st_next  = ST_ADDR;
      bit_next = 4'h0;
    end else if (stop) begin
      st_next = ST_IDLE;
    end else begin
      case (st_reg)
        ST_ADDR, ST_RX: begin
          if (rise) begin
            sh_next  = {sh_reg[6:0], sda_s2};
            bit_next = bit_reg + 4'h1;
          end else if (fall && bit_reg == IFX_BITS) begin
            bit_next = 4'h0;
            st_next  = ST_WAIT;
            if (st_reg == ST_ADDR) begin
              rw_next = sh_reg[0];
              match   = addr_hit;
              // R6: NACK until ready
              // R7: ready set by software
              if (addr_hit && rdy_reg) begin
                st_next = ST_AACK;
              end
            end else if (rb_rdy) begin
              rb_push = 1'b1;
              st_next = ST_RACK;
            end
          end
        end
        ST_AACK: if (fall) begin
          st_next = rw_reg ? ST_TLOAD : ST_RX;
        end
        ST_RACK: if (fall) begin
          st_next = ST_RX;
        end
        ST_TLOAD: begin
          if (tx_cnt_reg != 4'h0) begin
            tx_pop  = 1'b1;
            sh_next = tx_mem[tx_rd_reg];
            st_next = ST_TX;
          end else if (last_reg) begin
            // R3: end instead of stretching
            st_next = ST_WAIT;
          end
        end
        ST_TX: if (fall) begin
          sh_next  = {sh_reg[6:0], 1'b1};
          bit_next = bit_reg + 4'h1;
          if (bit_reg[2:0] == IFX_LAST_BIT) begin
            bit_next = 4'h0;
            st_next  = ST_TACK;
          end
        end
        ST_TACK: begin
          if (rise && sda_s2) begin
            st_next = ST_WAIT;
          end else if (fall) begin
            st_next = ST_TLOAD;
          end
        end
        default: st_next = st_reg;
      endcase
    end
    sda_oe_next = (st_next == ST_AACK) || (st_next == ST_RACK) ||
                  (st_next == ST_TX && !sh_next[7]);
    // R2: stretch while FIFO empty
    scl_oe_next = (st_next == ST_TLOAD) && (tx_cnt_reg == 4'h0) && !last_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg     <= ST_IDLE;
      bit_reg    <= 4'h0;
      sh_reg     <= 8'h0;
      rw_reg     <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else begin
      st_reg     <= st_next;
      bit_reg    <= bit_next;
      sh_reg     <= sh_next;
      rw_reg     <= rw_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_addr_done;
    st_reg == ST_ADDR && fall && bit_reg == IFX_BITS && !start && !stop;
  endsequence
  sequence s_dry;
    st_reg == ST_TLOAD && tx_cnt_reg == 4'h0 && !start && !stop;
  endsequence

  property p_cnt_rd;
    rd_en && req_reg.ofs == IFX_OFS_CTRL1 |=> hrdata_reg[11:8] == $past(tx_cnt_reg);
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count field wrong"); // R1
  property p_stretch;
    s_dry ##0 !last_reg |=> scl_oe_reg && st_reg == ST_TLOAD;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl not held"); // R2
  property p_release;
    s_dry ##0 last_reg |=> st_reg == ST_WAIT && !scl_oe_reg;
  endproperty
  a_release: assert property (p_release) else $error("scl not released"); // R3
  property p_last_clr;
    (start || stop) && !sw_last |=> !last_reg;
  endproperty
  a_last_clr: assert property (p_last_clr) else $error("last not cleared"); // R4
  property p_rdy_clr;
    wr_en && req_reg.ofs == IFX_OFS_CTRL0 && hwdata[0] && !preld_reg |=> !rdy_reg;
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared"); // R5
  property p_nack;
    s_addr_done ##0 !rdy_reg |=> st_reg == ST_WAIT ##1 !sda_oe_reg;
  endproperty
  a_nack: assert property (p_nack) else $error("address acked"); // R6
  property p_forced;
    !preld_reg |-> rdy_reg;
  endproperty
  a_forced: assert property (p_forced) else $error("ready not forced"); // R8
  property p_pop;
    rd_data && rx_cnt_reg != 4'h0 && !rxf_push |=> rx_cnt_reg == $past(rx_cnt_reg) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("rx not popped"); // R9
  property p_push;
    wr_data && tx_cnt_reg != IFX_FULL && !lock_reg && !tx_pop && !tx_flush
      |=> tx_cnt_reg == $past(tx_cnt_reg) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("tx not pushed"); // R10
  property p_empty_rd;
    rd_data && rx_cnt_reg == 4'h0 |=> hrdata_reg[7:0] == IFX_EMPTY_RD;
  endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("empty read wrong"); // R11
  property p_full_wr;
    wr_data && tx_cnt_reg == IFX_FULL && !tx_pop && !tx_flush |=> tx_cnt_reg == IFX_FULL;
  endproperty
  a_full_wr: assert property (p_full_wr) else $error("full write taken"); // R12
  property p_lock;
    s_addr_done ##0 addr_hit && !preld_reg |=> lock_reg && tx_cnt_reg == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("no flush and lock"); // R13
  property p_cap;
    tx_cnt_reg <= IFX_FULL && rx_cnt_reg <= IFX_FULL;
  endproperty
  a_cap: assert property (p_cap) else $error("count over capacity"); // R14
endmodule

// ===== ifx_i2c_txctl_test.sv
module ifx_i2c_txctl_test;
  import ifx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hready, hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe;
  logic        scl, sda, scl_pull, sda_pull, ack;
  logic [7:0]  b;
  logic [7:0]  q[$];
  int          error_cnt = 0;
  int          compares  = 0;

  assign hready = hreadyout;
  assign scl    = ~((scl_oe & ~scl_o) | scl_pull);
  assign sda    = ~((sda_oe & ~sda_o) | sda_pull);
  always #4 hclk = ~hclk;

  ifx_i2c_txctl ifx_i2c_txctl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  ifx_i2c_master_model ifx_i2c_master_model_inst (
    .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );

  function automatic logic [31:0] ctl1(input int cnt, input logic last, input logic rdy);
    return {20'h0, 4'(cnt), 6'h0, last, rdy};
  endfunction
  task automatic conclude();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single AHB transfer, bounded wait
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    rd = hrdata;
    if (n >= 64) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  initial begin
    void'($urandom(90));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(IFX_OFS_CTRL1, ctl1(0, 0, 1));
    rdc(IFX_OFS_DATA, {24'h0, IFX_EMPTY_RD});
    rdc(8'h60, 32'h0);
    for (int i = 0; i <= IFX_DEPTH; i++) begin
      ahb(1'b1, IFX_OFS_DATA, $urandom & 32'hFF);
      rdc(IFX_OFS_CTRL1, ctl1((i < IFX_DEPTH) ? i + 1 : IFX_DEPTH, 0, 1));
    end
    ahb(1'b1, IFX_OFS_CTRL0, 32'h80);
    rdc(IFX_OFS_CTRL1, ctl1(0, 0, 1));
    ahb(1'b1, IFX_OFS_DATA, 32'h5A);
    ifx_i2c_master_model_inst.start();
    ifx_i2c_master_model_inst.wr_byte({IFX_RST_SADDR, 1'b0}, ack);
    ifx_i2c_master_model_inst.stop();
    chk(ack, 1'b1);
    rdc(IFX_OFS_CTRL1, ctl1(0, 0, 1));
    rdc(IFX_OFS_STAT, 32'h1);
    ahb(1'b1, IFX_OFS_DATA, 32'h11);
    rdc(IFX_OFS_CTRL1, ctl1(0, 0, 1));
    ahb(1'b1, IFX_OFS_STAT, 32'h1);
    ahb(1'b1, IFX_OFS_DATA, 32'h22);
    rdc(IFX_OFS_CTRL1, ctl1(1, 0, 1));
    ifx_i2c_master_model_inst.start();
    ifx_i2c_master_model_inst.wr_byte({IFX_RST_SADDR, 1'b0}, ack);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      q.push_back(b);
      ifx_i2c_master_model_inst.wr_byte(b, ack);
      chk(ack, 1'b1);
    end
    ifx_i2c_master_model_inst.stop();
    while (q.size() > 0) rdc(IFX_OFS_DATA, {24'h0, q.pop_front()});
    rdc(IFX_OFS_DATA, {24'h0, IFX_EMPTY_RD});
    ahb(1'b1, IFX_OFS_STAT, 32'h1);
    ahb(1'b1, IFX_OFS_CTRL0, 32'h1);
    rdc(IFX_OFS_CTRL1, ctl1(0, 0, 0));
    ifx_i2c_master_model_inst.start();
    ifx_i2c_master_model_inst.wr_byte({IFX_RST_SADDR, 1'b1}, ack);
    ifx_i2c_master_model_inst.stop();
    chk(ack, 1'b0);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      q.push_back(b);
      ahb(1'b1, IFX_OFS_DATA, {24'h0, b});
    end
    ahb(1'b1, IFX_OFS_CTRL1, 32'h1);
    rdc(IFX_OFS_CTRL1, ctl1(2, 0, 1));
    ifx_i2c_master_model_inst.start();
    ifx_i2c_master_model_inst.wr_byte({IFX_RST_SADDR, 1'b1}, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < 2; i++) begin
      ifx_i2c_master_model_inst.rd_byte(1'b1, b);
      chk(b, q.pop_front());
    end
    fork
      ifx_i2c_master_model_inst.rd_byte(1'b1, b);
      begin
        repeat (60) @(posedge hclk);
        chk(scl_oe, 1'b1);
        q.push_back(8'($urandom));
        ahb(1'b1, IFX_OFS_DATA, {24'h0, q[0]});
        ahb(1'b1, IFX_OFS_CTRL1, 32'h2);
        rdc(IFX_OFS_CTRL1, ctl1(0, 1, 1));
      end
    join
    chk(b, q.pop_front());
    ifx_i2c_master_model_inst.stretch_ns = 0;
    ifx_i2c_master_model_inst.rd_byte(1'b0, b);
    chk(32'(ifx_i2c_master_model_inst.stretch_ns), 32'h0);
    chk(b, 8'hFF);
    ifx_i2c_master_model_inst.stop();
    rdc(IFX_OFS_CTRL1, ctl1(0, 0, 1));
    chk(ifx_i2c_master_model_inst.timed_out, 1'b0);
    conclude();
  end
endmodule

// ===== ifx_pkg.sv
package ifx_pkg;
  localparam logic [7:0] IFX_OFS_CTRL0  = 8'h24;
  localparam logic [7:0] IFX_OFS_CTRL1  = 8'h28;
  localparam logic [7:0] IFX_OFS_DATA   = 8'h2C;
  localparam logic [7:0] IFX_OFS_SADDR  = 8'h50;
  localparam logic [7:0] IFX_OFS_STAT   = 8'h54;
  localparam int         IFX_DEPTH      = 8;
  localparam logic [3:0] IFX_FULL       = 4'h8;
  localparam logic [3:0] IFX_BITS       = 4'h8;
  localparam logic [2:0] IFX_LAST_BIT   = 3'h7;
  localparam int         IFX_CNT_LSB    = 8;
  localparam int         IFX_B_PRELD    = 0;
  localparam int         IFX_B_FLUSH    = 7;
  localparam int         IFX_B_LAST     = 1;
  localparam int         IFX_B_RDY      = 0;
  localparam int         IFX_B_LOCK     = 0;
  localparam logic [7:0] IFX_EMPTY_RD   = 8'hFF;
  localparam logic [6:0] IFX_GCALL      = 7'h00;
  localparam logic [6:0] IFX_RST_SADDR  = 7'h2A;
  localparam logic       IFX_RST_RDY    = 1'b1;
  localparam logic [1:0] IFX_PH_IDLE    = 2'h0;
  localparam logic [1:0] IFX_PH_WAIT    = 2'h1;
  localparam logic [1:0] IFX_PH_DONE    = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TLOAD, ST_TX, ST_TACK, ST_WAIT
  } ifx_state_e;

  typedef struct packed {
    logic [7:0] ofs;
    logic       wr;
  } ifx_req_s;
endpackage
